//--- hw/rcf_pkg.sv
package rcf_pkg;

	// Bus geometry
	localparam int unsigned ADR_W = 8;
	localparam int unsigned DAT_W = 32;
	localparam int unsigned SEL_W = 4;

	// Register byte offsets
	localparam logic [ADR_W-1:0] OFS_CAUSE_FLAGS   = 8'h00;
	localparam logic [ADR_W-1:0] OFS_BOR_CONTROL   = 8'h04;
	localparam logic [ADR_W-1:0] OFS_BOR_FILT_CNT  = 8'h08;
	localparam logic [ADR_W-1:0] OFS_PIN_FILT_CNT  = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_STACK_OVF_EN  = 8'h10;
	localparam logic [ADR_W-1:0] OFS_STACK_BOTTOM  = 8'h14;

	// Cause flag bit positions
	localparam int unsigned BIT_POWER_ON   = 7;
	localparam int unsigned BIT_PIN_RESET  = 6;
	localparam int unsigned BIT_BROWNOUT   = 5;
	localparam int unsigned BIT_WATCHDOG   = 4;
	localparam int unsigned BIT_SOFTWARE   = 3;
	localparam int unsigned BIT_STACK_OVF  = 1;
	localparam int unsigned BIT_PORT_LOWV  = 0;
	localparam logic [7:0]  CAUSE_WR_MASK  = 8'hFB;

	// Brownout control fields
	localparam int unsigned BIT_BOR_EN      = 7;
	localparam int unsigned BIT_BOR_FILT_EN = 6;
	localparam int unsigned BOR_VSEL_LSB    = 0;
	localparam int unsigned BOR_VSEL_W      = 3;
	localparam logic [7:0]  BOR_CTL_WR_MASK = 8'hC7;

	// Stack overflow enable field
	localparam int unsigned BIT_STACK_OVF_EN = 0;
	localparam logic [7:0]  STACK_TOP_LIMIT  = 8'hFF;

	// Reset values
	localparam logic [7:0] RST_CAUSE_FLAGS  = 8'h80;
	localparam logic [7:0] RST_BOR_CONTROL  = 8'h80;
	localparam logic [7:0] RST_BOR_FILT_CNT = 8'h00;
	localparam logic [7:0] RST_PIN_FILT_CNT = 8'hFF;
	localparam logic [7:0] RST_STACK_OVF_EN = 8'h00;
	localparam logic [7:0] RST_STACK_BOTTOM = 8'h00;

	// Filter timing: count * 8 + 2 CPU clocks
	localparam int unsigned FILT_SCALE = 8;
	localparam int unsigned FILT_EXTRA = 2;

	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [SEL_W-1:0] sel;
		logic [DAT_W-1:0] dat;
	} rcf_wb_req_t;

	typedef struct packed {
		logic             ack;
		logic [DAT_W-1:0] dat;
	} rcf_wb_rsp_t;

	typedef struct packed {
		logic       push;
		logic       pop;
		logic [7:0] top;
	} rcf_stack_t;

endpackage : rcf_pkg

//--- hw/rcf_reset_cause.sv
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

module rcf_reset_cause #(
	parameter int unsigned FILT_W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire rcf_pkg::rcf_wb_req_t wb_req,
	output var  rcf_pkg::rcf_wb_rsp_t wb_rsp,
	input  wire logic         reset_pin_n,
	input  wire logic         bor_trip,
	input  wire logic         port_low_voltage_detect_trip,
	input  wire logic         wdt_reset,
	input  wire logic         sw_reset,
	input  wire rcf_pkg::rcf_stack_t stack_op,
	input  wire logic         power_down,
	output logic              sys_reset_q,
	output logic              bor_enable_q,
	output logic [2:0]        bor_vsel_q
);
	import rcf_pkg::*;

	localparam int unsigned CNT_W = FILT_W + 4;

	if (FILT_W < 1 || FILT_W > 8) begin : g_chk
		$error("FILT_W must be 1 to 8");
	end

	// Persistence in clocks for a filter count
	function automatic logic [CNT_W-1:0] filt_target(input logic [7:0] cnt);
		filt_target = CNT_W'(cnt[FILT_W-1:0]) * CNT_W'(FILT_SCALE) + CNT_W'(FILT_EXTRA);
	endfunction : filt_target

	// Debounce counter step, saturating at target minus one
	function automatic logic [CNT_W-1:0] filt_step(input logic active,
			input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] target);
		if (!active)
			filt_step = '0;
		else if (cnt >= target - CNT_W'(1))
			filt_step = target - CNT_W'(1);
		else
			filt_step = cnt + CNT_W'(1);
	endfunction : filt_step

	// Asynchronous inputs: two-stage synchronisers
	logic [1:0] pin_sync_q, pin_sync_d;
	logic [1:0] bor_sync_q, bor_sync_d;
	logic [1:0] plv_sync_q, plv_sync_d;

	always_comb begin
		pin_sync_d = {pin_sync_q[0], ~reset_pin_n};
		bor_sync_d = {bor_sync_q[0], bor_trip};
		plv_sync_d = {plv_sync_q[0], port_low_voltage_detect_trip};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_sync_q <= 2'h0;
			bor_sync_q <= 2'h0;
			plv_sync_q <= 2'h0;
		end else begin
			pin_sync_q <= pin_sync_d;
			bor_sync_q <= bor_sync_d;
			plv_sync_q <= plv_sync_d;
		end
	end

	logic pin_low;
	logic bor_low;
	logic plv_low;
	assign pin_low = pin_sync_q[1];
	assign bor_low = bor_sync_q[1];
	assign plv_low = plv_sync_q[1];

	// Registers
	logic [7:0] flags_q, flags_d;
	logic [7:0] ctl_q, ctl_d;
	logic [7:0] bor_cnt_reg_q, bor_cnt_reg_d;
	logic [7:0] pin_cnt_reg_q, pin_cnt_reg_d;
	logic [7:0] ovf_en_q, ovf_en_d;
	logic [7:0] bottom_q, bottom_d;

	// Bus decode; write lands on the edge that raises ack
	logic       access;
	logic       wr_en;
	logic [7:0] wdat;
	assign access = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	assign wr_en  = access && wb_req.we && wb_req.sel[0];
	assign wdat   = wb_req.dat[7:0];

	// Filter counters
	logic [CNT_W-1:0] bor_fcnt_q, bor_fcnt_d;
	logic [CNT_W-1:0] pin_fcnt_q, pin_fcnt_d;
	logic [CNT_W-1:0] bor_target;
	logic [CNT_W-1:0] pin_target;
	logic             bor_active;
	logic             bor_filt_on;
	logic             pin_filt_on;
	logic             bor_evt;
	logic             pin_evt;
	logic             plv_evt;
	logic             stack_ovf;
	logic             stack_evt;
	logic [7:0]       set_vec;

	always_comb begin
		bor_target  = filt_target(bor_cnt_reg_q);
		pin_target  = filt_target(pin_cnt_reg_q);
		bor_active  = bor_low && ctl_q[BIT_BOR_EN];
		// Power-down forces the pass-through path
		bor_filt_on = ctl_q[BIT_BOR_FILT_EN] && !power_down;
		pin_filt_on = !power_down;
		bor_fcnt_d  = filt_step(bor_active, bor_fcnt_q, bor_target);
		pin_fcnt_d  = filt_step(pin_low, pin_fcnt_q, pin_target);
		bor_evt = bor_active &&
			(!bor_filt_on || bor_fcnt_q >= bor_target - CNT_W'(1));
		pin_evt = pin_low &&
			(!pin_filt_on || pin_fcnt_q >= pin_target - CNT_W'(1));
		plv_evt   = plv_low;
		stack_ovf = (stack_op.push && stack_op.top == STACK_TOP_LIMIT) ||
			(stack_op.pop && stack_op.top == bottom_q);
		stack_evt = stack_ovf && ovf_en_q[BIT_STACK_OVF_EN];
		set_vec = 8'h00;
		set_vec[BIT_PIN_RESET] = pin_evt;
		set_vec[BIT_BROWNOUT]  = bor_evt;
		set_vec[BIT_WATCHDOG]  = wdt_reset;
		set_vec[BIT_SOFTWARE]  = sw_reset;
		set_vec[BIT_STACK_OVF] = stack_evt;
		set_vec[BIT_PORT_LOWV] = plv_evt;
	end

	// Register writes
	always_comb begin
		flags_d       = flags_q;
		ctl_d         = ctl_q;
		bor_cnt_reg_d = bor_cnt_reg_q;
		pin_cnt_reg_d = pin_cnt_reg_q;
		ovf_en_d      = ovf_en_q;
		bottom_d      = bottom_q;
		if (wr_en) begin
			case (wb_req.adr)
				OFS_CAUSE_FLAGS:  flags_d = flags_q & (wdat | ~CAUSE_WR_MASK);
				OFS_BOR_CONTROL:  ctl_d = wdat & BOR_CTL_WR_MASK;
				OFS_BOR_FILT_CNT: bor_cnt_reg_d = wdat;
				OFS_PIN_FILT_CNT: pin_cnt_reg_d = wdat;
				OFS_STACK_OVF_EN: ovf_en_d = {7'h00, wdat[BIT_STACK_OVF_EN]};
				OFS_STACK_BOTTOM: bottom_d = wdat;
				default: ;
			endcase
		end
		// Hardware set wins over a same-cycle clear; others untouched
		flags_d = flags_d | set_vec;
	end

	// Power-on reset is this block's own reset; other causes set flags and raise sys_reset_q
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q       <= RST_CAUSE_FLAGS;
			ctl_q         <= RST_BOR_CONTROL;
			bor_cnt_reg_q <= RST_BOR_FILT_CNT;
			pin_cnt_reg_q <= RST_PIN_FILT_CNT;
			ovf_en_q      <= RST_STACK_OVF_EN;
			bottom_q      <= RST_STACK_BOTTOM;
			bor_fcnt_q    <= '0;
			pin_fcnt_q    <= '0;
		end else begin
			flags_q       <= flags_d;
			ctl_q         <= ctl_d;
			bor_cnt_reg_q <= bor_cnt_reg_d;
			pin_cnt_reg_q <= pin_cnt_reg_d;
			ovf_en_q      <= ovf_en_d;
			bottom_q      <= bottom_d;
			bor_fcnt_q    <= bor_fcnt_d;
			pin_fcnt_q    <= pin_fcnt_d;
		end
	end

	// Bus answer and outputs
	rcf_wb_rsp_t rsp_d;
	logic        sys_reset_d;
	logic        bor_enable_d;
	logic [2:0]  bor_vsel_d;

	always_comb begin
		rsp_d.ack = access;
		rsp_d.dat = '0;
		if (access && !wb_req.we) begin
			case (wb_req.adr)
				OFS_CAUSE_FLAGS:  rsp_d.dat[7:0] = flags_q;
				OFS_BOR_CONTROL:  rsp_d.dat[7:0] = ctl_q;
				OFS_BOR_FILT_CNT: rsp_d.dat[7:0] = bor_cnt_reg_q;
				OFS_PIN_FILT_CNT: rsp_d.dat[7:0] = pin_cnt_reg_q;
				OFS_STACK_OVF_EN: rsp_d.dat[7:0] = ovf_en_q;
				OFS_STACK_BOTTOM: rsp_d.dat[7:0] = bottom_q;
				default:          rsp_d.dat = '0;
			endcase
		end
		// Held while any source stays active
		sys_reset_d  = |set_vec;
		bor_enable_d = ctl_d[BIT_BOR_EN];
		// Code 0..7 maps to 1.8/2.0/2.4/2.6/3.0/3.6/3.9/4.2 V trip
		bor_vsel_d   = ctl_d[BOR_VSEL_LSB +: BOR_VSEL_W];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_rsp       <= '0;
			sys_reset_q  <= 1'b0;
			bor_enable_q <= RST_BOR_CONTROL[BIT_BOR_EN];
			bor_vsel_q   <= RST_BOR_CONTROL[BOR_VSEL_LSB +: BOR_VSEL_W];
		end else begin
			wb_rsp       <= rsp_d;
			sys_reset_q  <= sys_reset_d;
			bor_enable_q <= bor_enable_d;
			bor_vsel_q   <= bor_vsel_d;
		end
	end

	// Check helpers: run lengths counted apart from the filter counters
	logic [CNT_W-1:0] bor_run_q, bor_run_d;
	logic [CNT_W-1:0] pin_run_q, pin_run_d;
	logic [CNT_W-1:0] bor_need;
	logic [CNT_W-1:0] pin_need;
	logic             cause_wr;
	logic             por_zero_wr;

	always_comb begin
		bor_run_d = bor_run_q;
		pin_run_d = pin_run_q;
		// Saturate so a long fault cannot wrap back into the window
		if (!bor_active) begin
			bor_run_d = '0;
		end else if (bor_run_q != '1) begin
			bor_run_d = bor_run_q + CNT_W'(1);
		end
		if (!pin_low) begin
			pin_run_d = '0;
		end else if (pin_run_q != '1) begin
			pin_run_d = pin_run_q + CNT_W'(1);
		end
		// Active cycles that must precede the qualifying one
		bor_need    = bor_target - CNT_W'(1);
		pin_need    = pin_target - CNT_W'(1);
		cause_wr    = wr_en && wb_req.adr == OFS_CAUSE_FLAGS;
		por_zero_wr = cause_wr && !wdat[BIT_POWER_ON];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bor_run_q <= '0;
			pin_run_q <= '0;
		end else begin
			bor_run_q <= bor_run_d;
			pin_run_q <= pin_run_d;
		end
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_por_flag_hold: assert property ($fell(flags_q[BIT_POWER_ON]) |-> $past(por_zero_wr))
		else $error("power-on flag fell without a zero write");
	a_pin_flag_set: assert property (pin_evt |=> flags_q[BIT_PIN_RESET])
		else $error("pin cause flag not set");
	a_bor_flag_set: assert property (bor_evt |=> flags_q[BIT_BROWNOUT])
		else $error("brownout cause flag not set");
	a_wdt_flag_set: assert property (wdt_reset |=> flags_q[BIT_WATCHDOG])
		else $error("watchdog cause flag not set");
	a_sw_flag_set: assert property (sw_reset |=> flags_q[BIT_SOFTWARE])
		else $error("software cause flag not set");
	a_plv_flag_set: assert property (plv_low |=> flags_q[BIT_PORT_LOWV])
		else $error("port low-voltage flag not set");
	a_flags_kept: assert property (set_vec == 8'h00 && !wr_en |=> $stable(flags_q))
		else $error("cause flags changed without a cause");
	a_bor_disabled: assert property (!ctl_q[BIT_BOR_EN] |-> !bor_evt && !set_vec[BIT_BROWNOUT])
		else $error("brownout event while detection off");
	a_bor_bypass: assert property (!bor_filt_on && bor_low && ctl_q[BIT_BOR_EN]
		|=> flags_q[BIT_BROWNOUT] && sys_reset_q)
		else $error("unfiltered brownout did not act at once");
	a_bor_min_wait: assert property ($rose(bor_active) && bor_filt_on && !power_down
		|-> !bor_evt)
		else $error("filtered brownout fired too early");
	a_bor_pd_bypass: assert property (power_down && bor_active |-> bor_evt)
		else $error("brownout filter active in power-down");
	a_pin_min_wait: assert property ($rose(pin_low) && !power_down && pin_need > CNT_W'(1)
		|-> !pin_evt ##1 (!pin_evt || power_down))
		else $error("pin reset accepted too early");
	a_pin_pd_bypass: assert property (power_down && pin_low |-> pin_evt)
		else $error("pin filter active in power-down");
	a_stack_gated: assert property (!ovf_en_q[BIT_STACK_OVF_EN] |-> !set_vec[BIT_STACK_OVF])
		else $error("stack overflow acted while disabled");
	a_ctl_reserved: assert property (ctl_q[5:3] == 3'h0)
		else $error("reserved control bits not zero");
	a_stack_push_ovf: assert property (stack_op.push && stack_op.top == STACK_TOP_LIMIT &&
		ovf_en_q[BIT_STACK_OVF_EN] |=> flags_q[BIT_STACK_OVF] && sys_reset_q)
		else $error("push overflow not caught");
	a_set_beats_clr: assert property (wr_en && wb_req.adr == OFS_CAUSE_FLAGS &&
		!wdat[BIT_BROWNOUT] && bor_evt |=> flags_q[BIT_BROWNOUT])
		else $error("flag lost to same-cycle clear");
	a_filt_restart: assert property (!bor_active |=> bor_fcnt_q == '0)
		else $error("brownout counter did not restart");
	a_pin_restart: assert property (!pin_low |=> pin_fcnt_q == '0)
		else $error("pin counter did not restart");
	a_bor_filt_len: assert property (bor_evt && bor_filt_on |-> bor_run_q >= bor_need)
		else $error("filtered brownout shorter than its window");
	a_bor_filt_due: assert property (bor_active && bor_filt_on && bor_run_q == bor_need
		|-> bor_evt)
		else $error("filtered brownout not taken when due");
	a_bor_unfilt: assert property (bor_active && !ctl_q[BIT_BOR_FILT_EN] |-> bor_evt)
		else $error("brownout delayed with filter off");
	a_bor_pd_flag: assert property (power_down && bor_active |=> flags_q[BIT_BROWNOUT])
		else $error("brownout in power-down left no flag");
	a_pin_filt_len: assert property (pin_evt && pin_filt_on |-> pin_run_q >= pin_need)
		else $error("filtered pin reset shorter than its window");
	a_pin_filt_due: assert property (pin_low && pin_filt_on && pin_run_q == pin_need
		|-> pin_evt)
		else $error("filtered pin reset not taken when due");
	a_pin_pd_flag: assert property (power_down && pin_low |=> flags_q[BIT_PIN_RESET])
		else $error("pin reset in power-down left no flag");
	a_stack_pop_ovf: assert property (stack_op.pop && stack_op.top == bottom_q &&
		ovf_en_q[BIT_STACK_OVF_EN] |=> flags_q[BIT_STACK_OVF])
		else $error("pop overflow not caught");
	a_ovf_flag_set: assert property (stack_evt |=> flags_q[BIT_STACK_OVF])
		else $error("stack overflow flag not set");
	a_req_raised: assert property (set_vec != 8'h00 |=> sys_reset_q)
		else $error("reset request missing");
	a_req_dropped: assert property (set_vec == 8'h00 |=> !sys_reset_q)
		else $error("reset request without a cause");
	a_ovf_en_bits: assert property (ovf_en_q[7:1] == 7'h00)
		else $error("stack enable reserved bits set");
	a_enable_copy: assert property (bor_enable_q == ctl_q[BIT_BOR_EN])
		else $error("brownout enable output stale");
	a_vsel_copy: assert property (bor_vsel_q == ctl_q[BOR_VSEL_LSB +: BOR_VSEL_W])
		else $error("threshold output stale");
	a_flag_fall_wr: assert property (|($past(flags_q) & ~flags_q) |-> $past(cause_wr))
		else $error("cause flag cleared without a write");
	a_flag_rise_cause: assert property ((flags_q & ~$past(flags_q)) ==
		($past(set_vec) & ~$past(flags_q)))
		else $error("cause flag rose without its source");
	a_flag_reserved: assert property (flags_q[2] == 1'b0)
		else $error("reserved cause flag set");

	c_bor_filtered: cover property (bor_filt_on && bor_evt);
	c_pin_filtered: cover property (pin_filt_on && pin_evt);
	c_flag_cleared: cover property ($fell(flags_q[BIT_POWER_ON]));
	c_stack_pop_ovf: cover property (stack_op.pop && stack_evt);
	c_set_vs_clear: cover property (cause_wr && set_vec != 8'h00);

endmodule : rcf_reset_cause

`default_nettype wire

//--- verif/rcf_far_side.sv
`timescale 1ns/1ns
`default_nettype none

// Reset pin, voltage detectors, watchdog, software and stack sources
module rcf_far_side (
	input  wire logic          clk,
	output logic               reset_pin_n,
	output logic               bor_trip,
	output logic               port_low_voltage_detect_trip,
	output logic               wdt_reset,
	output logic               sw_reset,
	output logic               power_down,
	output rcf_pkg::rcf_stack_t stack_op
);
	import rcf_pkg::*;

	// One bit per source: pin, brownout, port voltage, watchdog, software
	logic [4:0] act;

	assign reset_pin_n = ~act[0];
	assign bor_trip    = act[1];
	assign port_low_voltage_detect_trip   = act[2];
	assign wdt_reset   = act[3];
	assign sw_reset    = act[4];

	initial begin
		act        = '0;
		power_down = 1'b0;
		stack_op   = '0;
	end

	// Level held for n edges, then released
	task automatic drive(input int which, input int n);
		@(posedge clk);
		act[which] <= 1'b1;
		repeat (n) @(posedge clk);
		act[which] <= 1'b0;
	endtask : drive

	// Single-cycle push or pop; top is kept afterwards
	task automatic stk(input logic push, input logic pop, input logic [7:0] top);
		@(posedge clk);
		stack_op <= '{push: push, pop: pop, top: top};
		@(posedge clk);
		stack_op <= '{push: 1'b0, pop: 1'b0, top: top};
	endtask : stk

	task automatic pd(input logic v);
		@(posedge clk);
		power_down <= v;
	endtask : pd

endmodule : rcf_far_side

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
	import rcf_pkg::*;

	logic        clk;
	logic        rst;
	rcf_wb_req_t wb_req;
	rcf_wb_rsp_t wb_rsp;
	logic        reset_pin_n;
	logic        bor_trip;
	logic        port_low_voltage_detect_trip;
	logic        wdt_reset;
	logic        sw_reset;
	logic        power_down;
	rcf_stack_t  stack_op;
	logic        sys_reset_q;
	logic        bor_enable_q;
	logic [2:0]  bor_vsel_q;
	logic [31:0] rd;
	int          errors;
	int          num_checks;
	int          cycles;

	rcf_reset_cause DUT (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.reset_pin_n(reset_pin_n), .bor_trip(bor_trip), .port_low_voltage_detect_trip(port_low_voltage_detect_trip),
		.wdt_reset(wdt_reset), .sw_reset(sw_reset), .stack_op(stack_op),
		.power_down(power_down), .sys_reset_q(sys_reset_q),
		.bor_enable_q(bor_enable_q), .bor_vsel_q(bor_vsel_q));

	rcf_far_side far (.clk(clk), .reset_pin_n(reset_pin_n), .bor_trip(bor_trip),
		.port_low_voltage_detect_trip(port_low_voltage_detect_trip), .wdt_reset(wdt_reset), .sw_reset(sw_reset),
		.power_down(power_down), .stack_op(stack_op));

	always #10 clk = ~clk;

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	// Generous ceiling; the sequence needs about five hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h000000, wd}};
		do begin
			@(posedge clk);
		end while (wb_rsp.ack !== 1'b1);
		rd = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clk);
	endtask : wb

	task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 8'h00);
		chk(rd, exp);
	endtask : rchk

	// Settle through the synchronisers, compare flags, then clear them all
	task automatic cause(input logic [31:0] exp);
		repeat (5) @(posedge clk);
		rchk(OFS_CAUSE_FLAGS, exp);
		wb(1'b1, OFS_CAUSE_FLAGS, 8'h00);
	endtask : cause

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		wb_req = '0;
		errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(32'(bor_enable_q), 32'h1);
		chk(32'(bor_vsel_q), 32'h0);
		rchk(OFS_BOR_CONTROL, 32'h80);
		rchk(OFS_BOR_FILT_CNT, 32'h00);
		rchk(OFS_PIN_FILT_CNT, 32'hFF);
		rchk(OFS_STACK_OVF_EN, 32'h00);
		rchk(8'h3C, 32'h00);
		wb(1'b1, OFS_CAUSE_FLAGS, 8'hFF);
		cause(32'h80);
		rchk(OFS_CAUSE_FLAGS, 32'h00);
		wb(1'b1, OFS_BOR_CONTROL, 8'hFF);
		rchk(OFS_BOR_CONTROL, 32'hC7);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, OFS_BOR_CONTROL, 8'h80 | 8'(i));
			chk(32'(bor_vsel_q), 32'(i));
		end
		wb(1'b1, OFS_STACK_OVF_EN, 8'hFF);
		rchk(OFS_STACK_OVF_EN, 32'h01);
		// Filter off: a long count must not delay the brownout
		wb(1'b1, OFS_BOR_FILT_CNT, 8'hFF);
		far.drive(1, 3);
		cause(32'h20);
		far.drive(3, 1);
		far.drive(4, 1);
		cause(32'h18);
		far.drive(2, 3);
		cause(32'h01);
		// Count 1 needs ten steady cycles; two short lows must not add up
		wb(1'b1, OFS_PIN_FILT_CNT, 8'h01);
		far.drive(0, 9);
		far.drive(0, 9);
		cause(32'h00);
		far.drive(0, 10);
		cause(32'h40);
		wb(1'b1, OFS_BOR_FILT_CNT, 8'h01);
		wb(1'b1, OFS_BOR_CONTROL, 8'hC0);
		far.drive(1, 9);
		far.drive(1, 9);
		cause(32'h00);
		far.drive(1, 10);
		cause(32'h20);
		wb(1'b1, OFS_BOR_CONTROL, 8'h00);
		chk(32'(bor_enable_q), 32'h0);
		far.drive(1, 14);
		cause(32'h00);
		// Power-down drops both filters even with the longest counts
		wb(1'b1, OFS_BOR_CONTROL, 8'hC0);
		wb(1'b1, OFS_BOR_FILT_CNT, 8'hFF);
		wb(1'b1, OFS_PIN_FILT_CNT, 8'hFF);
		far.pd(1'b1);
		far.drive(0, 3);
		far.drive(1, 3);
		cause(32'h60);
		far.pd(1'b0);
		far.drive(1, 3);
		cause(32'h00);
		wb(1'b1, OFS_STACK_OVF_EN, 8'h00);
		far.stk(1'b1, 1'b0, 8'hFF);
		cause(32'h00);
		wb(1'b1, OFS_STACK_OVF_EN, 8'h01);
		far.stk(1'b1, 1'b0, 8'hFF);
		cause(32'h02);
		far.stk(1'b1, 1'b0, 8'hFE);
		cause(32'h00);
		wb(1'b1, OFS_STACK_BOTTOM, 8'h20);
		rchk(OFS_STACK_BOTTOM, 32'h20);
		far.stk(1'b0, 1'b1, 8'h20);
		cause(32'h02);
		// Clear lands while the watchdog is still asserting
		fork
			far.drive(3, 12);
			begin
				repeat (3) @(posedge clk);
				wb(1'b1, OFS_CAUSE_FLAGS, 8'h00);
				chk(32'(sys_reset_q), 32'h1);
			end
		join
		cause(32'h10);
		conclude();
	end

endmodule : tb

`default_nettype wire
